// [core/pifeb_top.sv]
// Functional notes
// - Serial port 2 done sets its flag; sticky until software clears.
// - Bus collision 2 sets its flag; sticky until software writes zero.
// - Async 2 receive flag reads one while receive buffer full; read-only.
// - Async 2 transmit flag reads one while transmit buffer empty.
// - Timer 4 period match sets its flag; sticky until software clears.
// - Capture/compare 3..5 events set their flags; software clears them.
// - A capture/compare unit in PWM mode never sets its flag.
// - Without priority levels, no peripheral request unless peripheral enable set.
// - Each source has its own enable: one passes, zero blocks.
// - Enable register 2 covers osc fail, comparators, bit 4 zero, others.
// - Enable register 3 covers port 2, collision 2, async 2, timer 4, ccp5..3.
// - All implemented flags and enables clear to zero at reset.
// - Priority bits act only while priority levels are enabled.
// - Flags set regardless of enables, so software may poll.
// - Priority bit one means high priority, zero means low.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module pifeb_top
	import pifeb_pkg::*;
(
	input  wire logic        I_REF_CLK,     // System clock, 100 MHz
	input  wire logic        I_RESETN,      // Async reset, active low
	input  wire logic        I_WB_CYC,      // Bus cycle
	input  wire logic        I_WB_STB,      // Bus strobe
	input  wire logic        I_WB_WE,       // Bus write enable
	input  wire logic [7:0]  I_WB_ADR,      // Bus byte address
	input  wire logic [3:0]  I_WB_SEL,      // Bus byte selects
	input  wire logic [31:0] I_WB_DAT,      // Bus write data
	output logic      [31:0] O_WB_DAT,      // Bus read data
	output logic             O_WB_ACK,      // Bus acknowledge
	input  wire logic        I_SP2_DONE,    // Serial port 2 transfer done pulse
	input  wire logic        I_BUS_COLL2,   // Bus collision 2 pulse
	input  wire logic        I_ASYNC2_RXF,  // Async 2 receive buffer full level
	input  wire logic        I_ASYNC2_TXE,  // Async 2 transmit buffer empty level
	input  wire logic        I_TMR4_MATCH,  // Timer 4 period match pulse
	input  wire logic [2:0]  I_CAPCMP_EVT,  // Capture/compare 5..3 event pulses
	input  wire logic [2:0]  I_CAPCMP_PWM,  // Capture/compare 5..3 in PWM mode
	input  wire logic [7:0]  I_FLAGS1,      // Flags of first request register
	input  wire logic [7:0]  I_FLAGS2,      // Flags of second request register
	output logic             O_IRQ_HIGH,    // High priority (or sole) request
	output logic             O_IRQ_LOW      // Low priority request
);
	pifeb_top_state_type st_r;
	pifeb_top_state_type st_nxt;
	pifeb_reg_if         rif ();
	logic [7:0]          flags3;
	logic [7:0]          set3;
	logic [7:0]          level3;
	logic                wr_flags;
	logic [7:0]          f2_impl;

	// Pending check over one register; pol selects the priority class
	function automatic logic pend(input logic [7:0] f, input logic [7:0] e,
		input logic [7:0] p, input logic use_p, input logic pol);
		logic [7:0] cls;
		cls = use_p ? (pol ? p : ~p) : 8'hFF;
		return |(f & e & cls);
	endfunction : pend

	// Bus slave: registered ack and read data
	pifeb_wb_slave u_wb (
		.i_clk    (I_REF_CLK),
		.i_resetn (I_RESETN),
		.i_cyc    (I_WB_CYC),
		.i_stb    (I_WB_STB),
		.i_we     (I_WB_WE),
		.i_adr    (I_WB_ADR),
		.i_sel    (I_WB_SEL),
		.i_dat    (I_WB_DAT),
		.o_dat    (O_WB_DAT),
		.o_ack    (O_WB_ACK),
		.rif      (rif.slave)
	);

	// Event inputs of the third flag register
	always_comb begin
		set3                        = 8'h00;
		set3[FLG_SERIAL_PORT2_DONE] = I_SP2_DONE;
		set3[FLG_BUS_COLLISION2]    = I_BUS_COLL2;
		set3[FLG_TIMER4_MATCH]      = I_TMR4_MATCH;
		set3[FLG_CAPCMP5]           = I_CAPCMP_EVT[2] & ~I_CAPCMP_PWM[2];
		set3[FLG_CAPCMP4]           = I_CAPCMP_EVT[1] & ~I_CAPCMP_PWM[1];
		set3[FLG_CAPCMP3]           = I_CAPCMP_EVT[0] & ~I_CAPCMP_PWM[0];
		level3                      = 8'h00;
		level3[FLG_ASYNC2_RX_FULL]  = I_ASYNC2_RXF;
		level3[FLG_ASYNC2_TX_EMPTY] = I_ASYNC2_TXE;
	end

	assign wr_flags = rif.wr && (rif.addr == PIFEB_OFF_FLAGS3);
	assign f2_impl  = I_FLAGS2 & PIFEB_SET2_IMPL;

	// Sticky flags with set-over-clear
	pifeb_flag_unit u_flags (
		.i_clk    (I_REF_CLK),
		.i_resetn (I_RESETN),
		.i_set    (set3),
		.i_level  (level3),
		.i_wr     (wr_flags),
		.i_wdata  (rif.wdata),
		.o_flags  (flags3)
	);

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		case (rif.addr)
			PIFEB_OFF_FLAGS3: rif.rdata = flags3;
			PIFEB_OFF_EN1:    rif.rdata = st_r.en1;
			PIFEB_OFF_EN2:    rif.rdata = st_r.en2;
			PIFEB_OFF_EN3:    rif.rdata = st_r.en3;
			PIFEB_OFF_PRIO1:  rif.rdata = st_r.prio1;
			PIFEB_OFF_PRIO2:  rif.rdata = st_r.prio2;
			PIFEB_OFF_PRIO3:  rif.rdata = st_r.prio3;
			PIFEB_OFF_FLAGS1: rif.rdata = I_FLAGS1;
			PIFEB_OFF_FLAGS2: rif.rdata = f2_impl;
			PIFEB_OFF_CTRL: begin
				rif.rdata                          = 8'h00;
				rif.rdata[CTRL_GLOBAL_IRQ_EN_BIT]  = st_r.global_irq_enable;
				rif.rdata[CTRL_PERIPH_IRQ_EN_BIT]  = st_r.peripheral_irq_enable;
				rif.rdata[CTRL_PRIO_LEVELS_EN_BIT] = st_r.priority_levels_enable;
			end
			default:          rif.rdata = PIFEB_BYTE_ZERO;
		endcase
	end

	// Register writes and request gating
	always_comb begin
		logic hi_any;
		logic lo_any;
		logic all_any;
		hi_any  = 1'b0;
		lo_any  = 1'b0;
		all_any = 1'b0;
		st_nxt  = st_r;
		if (rif.wr) begin
			case (rif.addr)
				PIFEB_OFF_EN1:   st_nxt.en1   = rif.wdata;
				PIFEB_OFF_EN2:   st_nxt.en2   = rif.wdata & PIFEB_SET2_IMPL;
				PIFEB_OFF_EN3:   st_nxt.en3   = rif.wdata;
				PIFEB_OFF_PRIO1: st_nxt.prio1 = rif.wdata;
				PIFEB_OFF_PRIO2: st_nxt.prio2 = rif.wdata & PIFEB_SET2_IMPL;
				PIFEB_OFF_PRIO3: st_nxt.prio3 = rif.wdata;
				PIFEB_OFF_CTRL: begin
					st_nxt.global_irq_enable  = rif.wdata[CTRL_GLOBAL_IRQ_EN_BIT];
					st_nxt.peripheral_irq_enable = rif.wdata[CTRL_PERIPH_IRQ_EN_BIT];
					st_nxt.priority_levels_enable = rif.wdata[CTRL_PRIO_LEVELS_EN_BIT];
				end
				default: ;
			endcase
		end
		// Sources pass only through their own enable bit
		all_any = pend(I_FLAGS1, st_r.en1, st_r.prio1, 1'b0, 1'b0)
			| pend(f2_impl, st_r.en2, st_r.prio2, 1'b0, 1'b0)
			| pend(flags3, st_r.en3, st_r.prio3, 1'b0, 1'b0);
		// One means high class, zero low, only with priority levels on
		hi_any = pend(I_FLAGS1, st_r.en1, st_r.prio1, 1'b1, 1'b1)
			| pend(f2_impl, st_r.en2, st_r.prio2, 1'b1, 1'b1)
			| pend(flags3, st_r.en3, st_r.prio3, 1'b1, 1'b1);
		lo_any = pend(I_FLAGS1, st_r.en1, st_r.prio1, 1'b1, 1'b0)
			| pend(f2_impl, st_r.en2, st_r.prio2, 1'b1, 1'b0)
			| pend(flags3, st_r.en3, st_r.prio3, 1'b1, 1'b0);
		if (st_r.priority_levels_enable) begin
			st_nxt.irq_hi = st_r.global_irq_enable & hi_any;
			st_nxt.irq_lo = st_r.global_irq_enable & st_r.peripheral_irq_enable & lo_any;
		end else begin
			// Single-level mode needs the peripheral enable
			st_nxt.irq_hi = st_r.global_irq_enable & st_r.peripheral_irq_enable & all_any;
			st_nxt.irq_lo = 1'b0;
		end
	end

	// Register the state; enables clear, priorities set at reset
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st_r.en1    <= PIFEB_EN_RST;
			st_r.en2    <= PIFEB_EN_RST;
			st_r.en3    <= PIFEB_EN_RST;
			st_r.prio1  <= PIFEB_PRIO_RST;
			st_r.prio2  <= PIFEB_PRIO_RST & PIFEB_SET2_IMPL;
			st_r.prio3  <= PIFEB_PRIO_RST;
			st_r.global_irq_enable    <= 1'b0;
			st_r.peripheral_irq_enable   <= 1'b0;
			st_r.priority_levels_enable   <= 1'b0;
			st_r.irq_hi <= 1'b0;
			st_r.irq_lo <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign O_IRQ_HIGH = st_r.irq_hi;
	assign O_IRQ_LOW  = st_r.irq_lo;

	// Checks on flag capture and request gating
	property p_sp2_done;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		I_SP2_DONE |=> flags3[FLG_SERIAL_PORT2_DONE];
	endproperty
	a_sp2_done: assert property (p_sp2_done)
		else $error("serial port 2 done flag not set");

	property p_coll2_sticky;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		flags3[FLG_BUS_COLLISION2] && !wr_flags |=> flags3[FLG_BUS_COLLISION2];
	endproperty
	a_coll2_sticky: assert property (p_coll2_sticky)
		else $error("collision flag dropped without a write");

	property p_rx_level;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		$fell(I_ASYNC2_RXF) |=> !flags3[FLG_ASYNC2_RX_FULL];
	endproperty
	a_rx_level: assert property (p_rx_level)
		else $error("receive flag still high after buffer emptied");

	property p_tx_level;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		I_ASYNC2_TXE ##1 I_ASYNC2_TXE |-> flags3[FLG_ASYNC2_TX_EMPTY];
	endproperty
	a_tx_level: assert property (p_tx_level)
		else $error("transmit flag does not follow buffer empty");

	property p_tmr4_set;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		I_TMR4_MATCH && wr_flags |=> flags3[FLG_TIMER4_MATCH];
	endproperty
	a_tmr4_set: assert property (p_tmr4_set)
		else $error("timer 4 match lost against a clear");

	property p_capcmp_set;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		I_CAPCMP_EVT[0] && !I_CAPCMP_PWM[0] |=> flags3[FLG_CAPCMP3] [*1];
	endproperty
	a_capcmp_set: assert property (p_capcmp_set)
		else $error("capture/compare 3 flag not set");

	property p_pwm_quiet;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		I_CAPCMP_PWM[2] && !flags3[FLG_CAPCMP5] && !wr_flags |=> !flags3[FLG_CAPCMP5];
	endproperty
	a_pwm_quiet: assert property (p_pwm_quiet)
		else $error("flag set while unit in PWM mode");

	property p_periph_gate;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		!st_r.priority_levels_enable && !st_r.peripheral_irq_enable |=> !O_IRQ_HIGH && !O_IRQ_LOW;
	endproperty
	a_periph_gate: assert property (p_periph_gate)
		else $error("request passed without peripheral enable");

	property p_enable_block;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		(st_r.en1 == 8'h00) && (st_r.en2 == 8'h00) && (st_r.en3 == 8'h00)
			|=> !O_IRQ_HIGH && !O_IRQ_LOW;
	endproperty
	a_enable_block: assert property (p_enable_block)
		else $error("request with every enable cleared");

	property p_req_path;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		!st_r.priority_levels_enable && st_r.global_irq_enable && st_r.peripheral_irq_enable && |(flags3 & st_r.en3) |=> O_IRQ_HIGH;
	endproperty
	a_req_path: assert property (p_req_path)
		else $error("enabled pending flag gave no request");

	property p_low_class;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		st_r.priority_levels_enable && st_r.global_irq_enable && st_r.peripheral_irq_enable && |(flags3 & st_r.en3 & ~st_r.prio3) |=> O_IRQ_LOW;
	endproperty
	a_low_class: assert property (p_low_class)
		else $error("low priority source gave no low request");

	// Level mirrors, software writes, request classes and the bus handshake
	property p_rx_rise;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		$rose(I_ASYNC2_RXF) |=> flags3[FLG_ASYNC2_RX_FULL];
	endproperty
	a_rx_rise: assert property (p_rx_rise)
		else $error("receive flag missed a full buffer");

	property p_tx_fell;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		$fell(I_ASYNC2_TXE) |=> !flags3[FLG_ASYNC2_TX_EMPTY];
	endproperty
	a_tx_fell: assert property (p_tx_fell)
		else $error("transmit flag still high after buffer filled");

	property p_level_ro;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		wr_flags && !I_ASYNC2_RXF && !I_ASYNC2_TXE
			|=> !flags3[FLG_ASYNC2_RX_FULL] && !flags3[FLG_ASYNC2_TX_EMPTY];
	endproperty
	a_level_ro: assert property (p_level_ro)
		else $error("read-only flag taken from a write");

	property p_sw_clear;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		wr_flags && !rif.wdata[FLG_SERIAL_PORT2_DONE] && !I_SP2_DONE |=> !flags3[FLG_SERIAL_PORT2_DONE];
	endproperty
	a_sw_clear: assert property (p_sw_clear)
		else $error("serial port 2 flag not cleared by software");

	property p_en1_write;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		rif.wr && (rif.addr == PIFEB_OFF_EN1) |=> st_r.en1 == $past(rif.wdata);
	endproperty
	a_en1_write: assert property (p_en1_write)
		else $error("enable register 1 did not take the write");

	property p_en2_write;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		rif.wr && (rif.addr == PIFEB_OFF_EN2) |=> st_r.en2 == ($past(rif.wdata) & PIFEB_SET2_IMPL);
	endproperty
	a_en2_write: assert property (p_en2_write)
		else $error("enable register 2 wrong after a write");

	property p_en3_write;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		rif.wr && (rif.addr == PIFEB_OFF_EN3) |=> st_r.en3 == $past(rif.wdata);
	endproperty
	a_en3_write: assert property (p_en3_write)
		else $error("enable register 3 did not take the write");

	property p_global_gate;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		!st_r.global_irq_enable |=> !O_IRQ_HIGH && !O_IRQ_LOW;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("request passed without global enable");

	property p_single_low;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		!st_r.priority_levels_enable |=> !O_IRQ_LOW;
	endproperty
	a_single_low: assert property (p_single_low)
		else $error("low request without priority levels");

	property p_high_class;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		st_r.priority_levels_enable && st_r.global_irq_enable && |(flags3 & st_r.en3 & st_r.prio3) |=> O_IRQ_HIGH;
	endproperty
	a_high_class: assert property (p_high_class)
		else $error("high priority source gave no high request");

	property p_ack_pulse;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		O_WB_ACK |=> !O_WB_ACK;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("bus acknowledge longer than one cycle");

	property p_ack_answer;
		@(posedge I_REF_CLK) disable iff (!I_RESETN)
		I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("bus request not answered in one cycle");

endmodule : pifeb_top

// [core/pifeb_pkg.sv]
package pifeb_pkg;

	// Register byte addresses on the bus
	localparam logic [7:0] PIFEB_OFF_FLAGS3 = 8'h00;
	localparam logic [7:0] PIFEB_OFF_EN1    = 8'h04;
	localparam logic [7:0] PIFEB_OFF_EN2    = 8'h08;
	localparam logic [7:0] PIFEB_OFF_EN3    = 8'h0C;
	localparam logic [7:0] PIFEB_OFF_CTRL   = 8'h10;
	localparam logic [7:0] PIFEB_OFF_PRIO1  = 8'h14;
	localparam logic [7:0] PIFEB_OFF_PRIO2  = 8'h18;
	localparam logic [7:0] PIFEB_OFF_PRIO3  = 8'h1C;
	localparam logic [7:0] PIFEB_OFF_FLAGS1 = 8'h20;
	localparam logic [7:0] PIFEB_OFF_FLAGS2 = 8'h24;

	// Bit positions in the third flag and enable registers
	localparam int unsigned FLG_SERIAL_PORT2_DONE = 7;
	localparam int unsigned FLG_BUS_COLLISION2    = 6;
	localparam int unsigned FLG_ASYNC2_RX_FULL    = 5;
	localparam int unsigned FLG_ASYNC2_TX_EMPTY   = 4;
	localparam int unsigned FLG_TIMER4_MATCH      = 3;
	localparam int unsigned FLG_CAPCMP5           = 2;
	localparam int unsigned FLG_CAPCMP4           = 1;
	localparam int unsigned FLG_CAPCMP3           = 0;

	// Control register bit positions
	localparam int unsigned CTRL_GLOBAL_IRQ_EN_BIT  = 7;
	localparam int unsigned CTRL_PERIPH_IRQ_EN_BIT  = 6;
	localparam int unsigned CTRL_PRIO_LEVELS_EN_BIT = 0;

	// Reset values and implemented-bit masks
	localparam logic [7:0] PIFEB_FLAG_RST     = 8'h00;
	localparam logic [7:0] PIFEB_EN_RST       = 8'h00;
	localparam logic [7:0] PIFEB_PRIO_RST     = 8'hFF;
	localparam logic [7:0] PIFEB_BYTE_ZERO    = 8'h00;
	localparam logic [7:0] PIFEB_SET2_IMPL    = 8'hEF;
	localparam logic [7:0] PIFEB_FLAGS3_SW    = 8'hCF;
	localparam logic [7:0] PIFEB_FLAGS3_LEVEL = 8'h30;

	// State of the bus slave
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pifeb_wb_state_type;

	// State of the flag register
	typedef struct packed {
		logic [7:0] flags;
	} pifeb_flag_state_type;

	// State of the top level
	typedef struct packed {
		logic [7:0] en1;
		logic [7:0] en2;
		logic [7:0] en3;
		logic [7:0] prio1;
		logic [7:0] prio2;
		logic [7:0] prio3;
		logic       global_irq_enable;
		logic       peripheral_irq_enable;
		logic       priority_levels_enable;
		logic       irq_hi;
		logic       irq_lo;
	} pifeb_top_state_type;

endpackage : pifeb_pkg

// [core/pifeb_reg_if.sv]
`timescale 1ns/1ps
interface pifeb_reg_if;
	logic       wr;    // One-cycle write strobe
	logic [7:0] addr;  // Byte address, word aligned
	logic [7:0] wdata; // Write data, low byte lane
	logic [7:0] rdata; // Read data for addr

	modport slave (output wr, addr, wdata, input rdata);
	modport regs  (input wr, addr, wdata, output rdata);
endinterface : pifeb_reg_if

// [core/pifeb_wb_slave.sv]
`timescale 1ns/1ps
module pifeb_wb_slave
	import pifeb_pkg::*;
(
	input  wire logic        i_clk,    // System clock
	input  wire logic        i_resetn, // Async reset, active low
	input  wire logic        i_cyc,    // Bus cycle
	input  wire logic        i_stb,    // Strobe
	input  wire logic        i_we,     // Write enable
	input  wire logic [7:0]  i_adr,    // Byte address
	input  wire logic [3:0]  i_sel,    // Byte selects
	input  wire logic [31:0] i_dat,    // Write data
	output logic      [31:0] o_dat,    // Read data
	output logic             o_ack,    // Acknowledge
	pifeb_reg_if.slave       rif       // Register side
);
	pifeb_wb_state_type st_r;
	pifeb_wb_state_type st_nxt;
	logic               req;

	// New request: the cycle in which ack is still low
	assign req       = i_cyc & i_stb & ~st_r.ack;
	assign rif.wr    = req & i_we & i_sel[0];
	assign rif.addr  = {i_adr[7:2], 2'b00};
	assign rif.wdata = i_dat[7:0];

	// Answer every access one cycle later; ack drops after one cycle
	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = req;
		if (req) begin
			st_nxt.dat = {24'h000000, i_we ? PIFEB_BYTE_ZERO : rif.rdata};
		end
	end

	// Register the state
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_ack = st_r.ack;
	assign o_dat = st_r.dat;
endmodule : pifeb_wb_slave

// [core/pifeb_flag_unit.sv]
`timescale 1ns/1ps
module pifeb_flag_unit
	import pifeb_pkg::*;
(
	input  wire logic       i_clk,    // System clock
	input  wire logic       i_resetn, // Async reset, active low
	input  wire logic [7:0] i_set,    // One-cycle set events
	input  wire logic [7:0] i_level,  // Levels for read-only bits
	input  wire logic       i_wr,     // Software write strobe
	input  wire logic [7:0] i_wdata,  // Software write data
	output logic      [7:0] o_flags   // Current flags
);
	pifeb_flag_state_type st_r;
	pifeb_flag_state_type st_nxt;

	// Software writes the sticky bits; a set in the same cycle wins
	always_comb begin
		st_nxt = st_r;
		if (i_wr) begin
			st_nxt.flags = i_wdata & PIFEB_FLAGS3_SW;
		end
		st_nxt.flags = ((st_nxt.flags | i_set) & PIFEB_FLAGS3_SW)
			| (i_level & PIFEB_FLAGS3_LEVEL);
	end

	// Register the state, cleared at reset
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r.flags <= PIFEB_FLAG_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_flags = st_r.flags;
endmodule : pifeb_flag_unit

// [testbench/pifeb_periph_model.sv]
`timescale 1ns/1ps
module pifeb_periph_model (
	input  wire logic       i_clk,      // System clock
	output logic            o_sp2_done, // Serial port 2 done pulse
	output logic            o_coll2,    // Bus collision 2 pulse
	output logic            o_rx_full,  // Async 2 receive buffer full
	output logic            o_tx_empty, // Async 2 transmit buffer empty
	output logic            o_tmr4,     // Timer 4 match pulse
	output logic      [2:0] o_cc_evt,   // Capture/compare 5..3 events
	output logic      [2:0] o_cc_pwm    // Capture/compare 5..3 in PWM mode
);
	// Quiet peripherals from time zero so the flags see no stray events
	initial begin
		o_sp2_done = 1'b0;
		o_coll2    = 1'b0;
		o_rx_full  = 1'b0;
		o_tx_empty = 1'b0;
		o_tmr4     = 1'b0;
		o_cc_evt   = 3'h0;
		o_cc_pwm   = 3'h0;
	end

	// One-cycle events, mask laid out like the flag register; bits 5 and 4 are levels, not events
	task automatic fire(input logic [7:0] mask);
		o_sp2_done <= mask[7];
		o_coll2    <= mask[6];
		o_tmr4     <= mask[3];
		o_cc_evt   <= mask[2:0];
		@(posedge i_clk);
		o_sp2_done <= 1'b0;
		o_coll2    <= 1'b0;
		o_tmr4     <= 1'b0;
		o_cc_evt   <= 3'h0;
	endtask : fire

	// Buffer levels and PWM modes; dropping rx models a read of the receive buffer
	task automatic set_bufs(input logic rx, input logic tx, input logic [2:0] pwm);
		o_rx_full  <= rx;
		o_tx_empty <= tx;
		o_cc_pwm   <= pwm;
	endtask : set_bufs
endmodule : pifeb_periph_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import pifeb_pkg::*;
	logic        clk, resetn, cyc, stb, we, ack, irq_hi, irq_lo;
	logic        sp2, coll2, rxf, txe, tmr4;
	logic [2:0]  cc_evt, cc_pwm;
	logic [3:0]  sel;
	logic [7:0]  adr, flags1, flags2;
	logic [31:0] wdat, rdat;
	int          failures, n_tests, cycles;

	pifeb_top DUT (.I_REF_CLK(clk), .I_RESETN(resetn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_SP2_DONE(sp2), .I_BUS_COLL2(coll2), .I_ASYNC2_RXF(rxf), .I_ASYNC2_TXE(txe),
		.I_TMR4_MATCH(tmr4), .I_CAPCMP_EVT(cc_evt), .I_CAPCMP_PWM(cc_pwm), .I_FLAGS1(flags1),
		.I_FLAGS2(flags2), .O_IRQ_HIGH(irq_hi), .O_IRQ_LOW(irq_lo));

	pifeb_periph_model periph (.i_clk(clk), .o_sp2_done(sp2), .o_coll2(coll2), .o_rx_full(rxf),
		.o_tx_empty(txe), .o_tmr4(tmr4), .o_cc_evt(cc_evt), .o_cc_pwm(cc_pwm));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// Whole run needs well under a thousand cycles; a hang ends here
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	// Requests are compared as {high, low}
	task automatic chk_irq(input logic [1:0] exp);
		n_tests++;
		if ({irq_hi, irq_lo} !== exp) begin
			failures++;
			$display("ERROR t=%0t irq got=%h exp=%h", $time, {irq_hi, irq_lo}, exp);
		end
	endtask : chk_irq

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	// Classic cycle: request held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [31:0] q);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		sel  <= s;
		adr  <= a;
		wdat <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hF, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, 4'hF, q);
		chk_reg(q, {24'h000000, exp});
	endtask : rd_chk

	task automatic t_regs;
		logic [31:0] q;
		rd_chk(PIFEB_OFF_FLAGS3, 8'h00);
		rd_chk(PIFEB_OFF_EN2, 8'h00);
		wr(PIFEB_OFF_EN1, 8'hFF);
		rd_chk(PIFEB_OFF_EN1, 8'hFF);
		wr(PIFEB_OFF_EN2, 8'hFF);
		rd_chk(PIFEB_OFF_EN2, 8'hEF);
		wr(PIFEB_OFF_EN3, 8'hA5);
		rd_chk(PIFEB_OFF_EN3, 8'hA5);
		// Low byte lane not selected: the write is acked but ignored
		wb(1'b1, PIFEB_OFF_EN3, 8'h5A, 4'hE, q);
		rd_chk(PIFEB_OFF_EN3, 8'hA5);
		wr(8'h30, 8'hFF);
		rd_chk(8'h30, 8'h00);
		wr(PIFEB_OFF_EN1, 8'h00);
		wr(PIFEB_OFF_EN2, 8'h00);
		wr(PIFEB_OFF_EN3, 8'h00);
	endtask : t_regs

	// All enables off: flags must still set, so software can poll
	task automatic t_flags;
		periph.fire(8'hFF);
		idle(2);
		rd_chk(PIFEB_OFF_FLAGS3, 8'hCF);
		periph.set_bufs(1'b1, 1'b1, 3'h0);
		idle(2);
		rd_chk(PIFEB_OFF_FLAGS3, 8'hFF);
		wr(PIFEB_OFF_FLAGS3, 8'h00);
		rd_chk(PIFEB_OFF_FLAGS3, 8'h30);
		periph.set_bufs(1'b0, 1'b0, 3'h0);
		idle(2);
		rd_chk(PIFEB_OFF_FLAGS3, 8'h00);
		// Level bits are read-only: writing ones must not set them
		wr(PIFEB_OFF_FLAGS3, 8'h30);
		rd_chk(PIFEB_OFF_FLAGS3, 8'h00);
	endtask : t_flags

	// Units 5 and 3 in PWM mode, unit 4 still capturing
	task automatic t_pwm;
		periph.set_bufs(1'b0, 1'b0, 3'h5);
		periph.fire(8'h07);
		idle(2);
		rd_chk(PIFEB_OFF_FLAGS3, 8'h02);
		wr(PIFEB_OFF_FLAGS3, 8'h00);
		periph.set_bufs(1'b0, 1'b0, 3'h0);
	endtask : t_pwm

	// Timer 4 match lands on the same edge as a clear: the set must win
	task automatic t_gate;
		fork
			periph.fire(8'h08);
			wr(PIFEB_OFF_FLAGS3, 8'h00);
		join
		rd_chk(PIFEB_OFF_FLAGS3, 8'h08);
		wr(PIFEB_OFF_EN3, 8'h08);
		wr(PIFEB_OFF_CTRL, 8'h80);
		idle(3);
		chk_irq(2'b00);
		wr(PIFEB_OFF_CTRL, 8'hC0);
		idle(3);
		chk_irq(2'b10);
		wr(PIFEB_OFF_EN3, 8'h00);
		idle(3);
		chk_irq(2'b00);
		flags1 <= 8'h80;
		wr(PIFEB_OFF_EN1, 8'h80);
		idle(3);
		chk_irq(2'b10);
		flags1 <= 8'h00;
		wr(PIFEB_OFF_EN1, 8'h00);
		// Second flag register: bit 4 has no enable, bit 0 does
		flags2 <= 8'hFF;
		wr(PIFEB_OFF_EN2, 8'h10);
		idle(3);
		chk_irq(2'b00);
		wr(PIFEB_OFF_EN2, 8'h01);
		idle(3);
		chk_irq(2'b10);
		rd_chk(PIFEB_OFF_FLAGS2, 8'hEF);
		flags2 <= 8'h00;
		wr(PIFEB_OFF_EN2, 8'h00);
	endtask : t_gate

	// Timer 4 flag is still set from the gating check
	task automatic t_prio;
		wr(PIFEB_OFF_EN3, 8'h08);
		wr(PIFEB_OFF_CTRL, 8'h81);
		idle(3);
		chk_irq(2'b10);
		wr(PIFEB_OFF_PRIO3, 8'hF7);
		idle(3);
		chk_irq(2'b00);
		wr(PIFEB_OFF_CTRL, 8'hC1);
		idle(3);
		chk_irq(2'b01);
		wr(PIFEB_OFF_CTRL, 8'hC0);
		idle(3);
		chk_irq(2'b10);
	endtask : t_prio

	// Reset in mid-run with a request standing
	task automatic t_rereset;
		resetn <= 1'b0;
		idle(2);
		resetn <= 1'b1;
		idle(1);
		chk_irq(2'b00);
		rd_chk(PIFEB_OFF_FLAGS3, 8'h00);
		rd_chk(PIFEB_OFF_EN3, 8'h00);
	endtask : t_rereset

	initial begin
		failures = 0;
		n_tests  = 0;
		cycles   = 0;
		resetn   = 1'b0;
		cyc      = 1'b0;
		stb      = 1'b0;
		we       = 1'b0;
		adr      = 8'h00;
		sel      = 4'hF;
		wdat     = 32'h00000000;
		flags1   = 8'h00;
		flags2   = 8'h00;
		idle(2);
		resetn <= 1'b1;
		idle(1);
		t_regs();
		t_flags();
		t_pwm();
		t_gate();
		t_prio();
		t_rereset();
		give_verdict();
	end
endmodule : testbench
